// ===== tlic_ctrl.sv
// two-level interrupt controller with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module tlic_ctrl
	import tlic_pkg::*;
#(
	parameter int NUM_PERIPH_REGS = TLIC_NREG
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// event sources, one-cycle pulses
	input wire logic i_ext0_event,
	input wire logic [1:0] i_core_event,
	input wire logic [8*NUM_PERIPH_REGS-1:0] i_periph_event,
	// core handshake
	input wire logic i_core_ack,
	input wire logic i_return_from_irq,
	output logic o_core_irq,
	output logic [15:0] o_core_vector,
	// interrupt
	output logic o_irq,
	// axi4-lite write address, data and response
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// only the five-register bank layout is decoded
	if (NUM_PERIPH_REGS != TLIC_NREG) begin : g_bad_param
		$error("tlic_ctrl: NUM_PERIPH_REGS must be 5");
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] flag_reg [NUM_PERIPH_REGS];
	logic [7:0] en_reg [NUM_PERIPH_REGS];
	logic [7:0] prio_reg [NUM_PERIPH_REGS];
	logic priority_mode_enable_reg;
	logic [TLIC_NEVT-1:0] istat_reg;
	logic [TLIC_NEVT-1:0] imask_reg;
	tlic_svc_t svc_reg;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rdata_next;
	logic rd_ok;
	logic wr_ok;

	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// write strobe for the low byte, where all fields live
	logic wr_lane0;
	assign wr_lane0 = wr_fire && wstrb_reg[0];

	// address decode helpers
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		in_bank = (a >= base) && (a < base + 8'(4 * TLIC_NREG)) && (a[1:0] == 2'b00);
	endfunction

	always_comb begin
		wr_ok = 1'b1;
		case (awaddr_reg)
			TLIC_CTRL0_OFS, TLIC_CTRL1_OFS, TLIC_CTRL2_OFS, TLIC_RCTL_OFS,
			TLIC_ISTAT_OFS, TLIC_IMASK_OFS, TLIC_SVC_OFS: wr_ok = 1'b1;
			default: begin
				wr_ok = in_bank(awaddr_reg, TLIC_FLAG_OFS) || in_bank(awaddr_reg, TLIC_EN_OFS)
					|| in_bank(awaddr_reg, TLIC_PRIO_OFS);
			end
		endcase
	end

	// ---------------------------------------------------------------
	// arbitration
	// ---------------------------------------------------------------
	logic [8*NUM_PERIPH_REGS-1:0] p_flag;
	logic [8*NUM_PERIPH_REGS-1:0] p_en;
	logic [8*NUM_PERIPH_REGS-1:0] p_prio;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH_REGS; gi++) begin : g_flat
			assign p_flag[8*gi +: 8] = flag_reg[gi];
			assign p_en[8*gi +: 8] = en_reg[gi];
			assign p_prio[8*gi +: 8] = prio_reg[gi];
		end
	endgenerate

	logic geh;
	logic gel;
	logic ext0_act;
	logic [1:0] core_act;
	logic [1:0] core_prio;
	logic periph_hi;
	logic periph_lo;
	logic core_hi;
	logic core_lo;
	logic req_hi;
	logic req_lo;
	logic take_hi;
	logic take_lo;

	assign geh = ctrl0_reg[TLIC_HIGH_LEVEL_GLOBAL_ENABLE_BIT];
	assign gel = ctrl0_reg[TLIC_LOW_LEVEL_GLOBAL_ENABLE_BIT];
	// core sources: timer flag bit 2 / enable 5, change flag 0 / enable 3
	assign ext0_act = ctrl0_reg[TLIC_EXT0_FLAG_BIT] && ctrl0_reg[TLIC_EXT0_EN_BIT];
	assign core_act = {ctrl0_reg[2] && ctrl0_reg[5], ctrl0_reg[0] && ctrl0_reg[3]};
	assign core_prio = {ctrl1_reg[2], ctrl1_reg[0]};
	assign periph_hi = |(p_flag & p_en & p_prio);
	assign periph_lo = |(p_flag & p_en & ~p_prio);
	assign core_hi = |(core_act & core_prio);
	assign core_lo = |(core_act & ~core_prio);

	always_comb begin
		if (priority_mode_enable_reg) begin
			req_hi = geh && (ext0_act || core_hi || periph_hi);
			req_lo = geh && gel && (core_lo || periph_lo);
		end else begin
			// priority selects play no part here
			req_hi = geh && (ext0_act || (|core_act) || (gel && |(p_flag & p_en)));
			req_lo = 1'b0;
		end
	end

	// high pre-empts low service; low waits while any service runs
	assign take_hi = req_hi && !svc_reg[1] && !o_core_irq;
	assign take_lo = req_lo && !req_hi && (svc_reg == TLIC_SVC_NONE) && !o_core_irq;

	// ---------------------------------------------------------------
	// core request and vector
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_irq <= 1'b0;
			o_core_vector <= TLIC_VEC_HIGH;
		end else if (take_hi) begin
			o_core_irq <= 1'b1;
			o_core_vector <= TLIC_VEC_HIGH;
		end else if (take_lo) begin
			o_core_irq <= 1'b1;
			o_core_vector <= TLIC_VEC_LOW;
		end else if (i_core_ack) begin
			o_core_irq <= 1'b0;
		end
	end

	// service state: entry on take, leave on return
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			svc_reg <= TLIC_SVC_NONE;
		end else if (take_hi) begin
			svc_reg <= tlic_svc_t'({1'b1, svc_reg[0]});
		end else if (take_lo) begin
			svc_reg <= TLIC_SVC_LOW;
		end else if (i_return_from_irq) begin
			case (svc_reg)
				TLIC_SVC_BOTH: svc_reg <= TLIC_SVC_LOW;
				TLIC_SVC_HIGH: svc_reg <= TLIC_SVC_NONE;
				TLIC_SVC_LOW: svc_reg <= TLIC_SVC_NONE;
				default: svc_reg <= TLIC_SVC_NONE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	logic [7:0] ctrl0_set;
	always_comb begin
		ctrl0_set = 8'h00;
		ctrl0_set[TLIC_EXT0_FLAG_BIT] = i_ext0_event;
		ctrl0_set[2] = i_core_event[1];
		ctrl0_set[0] = i_core_event[0];
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl0_reg <= TLIC_CTRL0_RST;
			ctrl1_reg <= TLIC_CTRL1_RST;
			ctrl2_reg <= TLIC_CTRL2_RST;
			priority_mode_enable_reg <= 1'b0;
		end else begin
			if (wr_lane0 && awaddr_reg == TLIC_CTRL0_OFS)
				ctrl0_reg <= wdata_reg[7:0] | ctrl0_set;
			else
				ctrl0_reg <= ctrl0_reg | ctrl0_set;
			if (take_hi)
				ctrl0_reg[TLIC_HIGH_LEVEL_GLOBAL_ENABLE_BIT] <= 1'b0;
			else if (take_lo)
				ctrl0_reg[TLIC_LOW_LEVEL_GLOBAL_ENABLE_BIT] <= 1'b0;
			else if (i_return_from_irq) begin
				if (!priority_mode_enable_reg || svc_reg[1])
					ctrl0_reg[TLIC_HIGH_LEVEL_GLOBAL_ENABLE_BIT] <= 1'b1;
				else
					ctrl0_reg[TLIC_LOW_LEVEL_GLOBAL_ENABLE_BIT] <= 1'b1;
			end
			if (wr_lane0 && awaddr_reg == TLIC_CTRL1_OFS)
				ctrl1_reg <= wdata_reg[7:0] & 8'hf5;
			if (wr_lane0 && awaddr_reg == TLIC_CTRL2_OFS)
				ctrl2_reg <= wdata_reg[7:0];
			if (wr_lane0 && awaddr_reg == TLIC_RCTL_OFS)
				priority_mode_enable_reg <= wdata_reg[TLIC_PMODE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// flag, enable and priority banks
	// ---------------------------------------------------------------
	generate
		for (gi = 0; gi < NUM_PERIPH_REGS; gi++) begin : g_bank
			logic [7:0] ofs;
			assign ofs = 8'(4 * gi);
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					flag_reg[gi] <= 8'h00;
					en_reg[gi] <= 8'h00;
					prio_reg[gi] <= 8'hff;
				end else begin
					// flags set by events always, even over a write
					if (wr_lane0 && awaddr_reg == TLIC_FLAG_OFS + ofs)
						flag_reg[gi] <= wdata_reg[7:0] | i_periph_event[8*gi +: 8];
					else
						flag_reg[gi] <= flag_reg[gi] | i_periph_event[8*gi +: 8];
					if (wr_lane0 && awaddr_reg == TLIC_EN_OFS + ofs)
						en_reg[gi] <= wdata_reg[7:0];
					if (wr_lane0 && awaddr_reg == TLIC_PRIO_OFS + ofs)
						prio_reg[gi] <= wdata_reg[7:0];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// interrupt status and mask
	// ---------------------------------------------------------------
	logic [TLIC_NEVT-1:0] evt;
	assign evt = {i_return_from_irq, take_lo, take_hi};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			istat_reg <= '0;
			imask_reg <= '0;
		end else begin
			if (wr_lane0 && awaddr_reg == TLIC_ISTAT_OFS)
				istat_reg <= (istat_reg & ~wdata_reg[TLIC_NEVT-1:0]) | evt;
			else
				istat_reg <= istat_reg | evt;
			if (wr_lane0 && awaddr_reg == TLIC_IMASK_OFS)
				imask_reg <= wdata_reg[TLIC_NEVT-1:0];
		end
	end

	assign o_irq = |(istat_reg & imask_reg);

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			TLIC_CTRL0_OFS: rdata_next[7:0] = ctrl0_reg;
			TLIC_CTRL1_OFS: rdata_next[7:0] = ctrl1_reg;
			TLIC_CTRL2_OFS: rdata_next[7:0] = ctrl2_reg;
			TLIC_RCTL_OFS: rdata_next[TLIC_PMODE_BIT] = priority_mode_enable_reg;
			TLIC_ISTAT_OFS: rdata_next[TLIC_NEVT-1:0] = istat_reg;
			TLIC_IMASK_OFS: rdata_next[TLIC_NEVT-1:0] = imask_reg;
			TLIC_SVC_OFS: rdata_next[1:0] = svc_reg;
			default: begin
				rd_ok = 1'b0;
				for (int i = 0; i < NUM_PERIPH_REGS; i++) begin
					if (s_axi_araddr == TLIC_FLAG_OFS + 8'(4 * i)) begin
						rdata_next[7:0] = flag_reg[i];
						rd_ok = 1'b1;
					end
					if (s_axi_araddr == TLIC_EN_OFS + 8'(4 * i)) begin
						rdata_next[7:0] = en_reg[i];
						rd_ok = 1'b1;
					end
					if (s_axi_araddr == TLIC_PRIO_OFS + 8'(4 * i)) begin
						rdata_next[7:0] = prio_reg[i];
						rd_ok = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== tlic_pkg.sv
// package of constants for the two-level interrupt controller
package tlic_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] TLIC_CTRL0_OFS = 8'h00;
	localparam logic [7:0] TLIC_CTRL1_OFS = 8'h04;
	localparam logic [7:0] TLIC_CTRL2_OFS = 8'h08;
	localparam logic [7:0] TLIC_FLAG_OFS = 8'h10;
	localparam logic [7:0] TLIC_EN_OFS = 8'h30;
	localparam logic [7:0] TLIC_PRIO_OFS = 8'h50;
	localparam logic [7:0] TLIC_RCTL_OFS = 8'h70;
	localparam logic [7:0] TLIC_ISTAT_OFS = 8'h74;
	localparam logic [7:0] TLIC_IMASK_OFS = 8'h78;
	localparam logic [7:0] TLIC_SVC_OFS = 8'h7c;
	localparam int TLIC_NREG = 5;
	// ---------------------------------------------------------------
	// control register 0 and priority mode fields
	// ---------------------------------------------------------------
	localparam int TLIC_HIGH_LEVEL_GLOBAL_ENABLE_BIT = 7;
	localparam int TLIC_LOW_LEVEL_GLOBAL_ENABLE_BIT = 6;
	localparam int TLIC_EXT0_EN_BIT = 4;
	localparam int TLIC_EXT0_FLAG_BIT = 1;
	localparam int TLIC_PMODE_BIT = 7;
	// ---------------------------------------------------------------
	// vectors and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] TLIC_VEC_HIGH = 16'h0008;
	localparam logic [15:0] TLIC_VEC_LOW = 16'h0018;
	localparam logic [7:0] TLIC_CTRL0_RST = 8'h00;
	localparam logic [7:0] TLIC_CTRL1_RST = 8'hf5;
	localparam logic [7:0] TLIC_CTRL2_RST = 8'hc0;
	// interrupt status bits: 0 high taken, 1 low taken, 2 return
	localparam int TLIC_NEVT = 3;
	typedef enum logic [1:0] {
		TLIC_SVC_NONE = 2'b00,
		TLIC_SVC_LOW = 2'b01,
		TLIC_SVC_HIGH = 2'b10,
		TLIC_SVC_BOTH = 2'b11
	} tlic_svc_t;
endpackage

// ===== tlic_monitor.sv
// assertion checker for the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module tlic_monitor (
	// clock, reset and core link
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_core_ack,
	input wire logic o_core_irq,
	input wire logic [15:0] o_core_vector,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_req_held;
		o_core_irq && !i_core_ack;
	endsequence
	a_req_held: assert property (s_req_held |=> o_core_irq && $stable(o_core_vector))
		else $error("core request dropped or its vector moved");
	a_req_drop: assert property (o_core_irq && i_core_ack |=> !o_core_irq)
		else $error("core request kept after acknowledge");
	a_vec_legal: assert property ($rose(o_core_irq) |-> o_core_vector inside {16'h0008, 16'h0018})
		else $error("core vector not a documented address");
	a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
		else $error("write response code illegal");
endmodule
`default_nettype wire

// ===== tlic_core_model.sv
// processor core model: accepts requests and issues returns
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// controller side
	input wire logic i_core_irq,
	input wire logic [15:0] i_core_vector,
	output logic o_core_ack,
	output logic o_return,
	// bench control
	input wire logic [3:0] i_delay,
	input wire logic i_ret_cmd,
	output logic [15:0] o_vec_seen,
	output logic [7:0] o_n_taken
);
	logic [3:0] wait_reg;
	// accept after the chosen delay and load the vector
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_ack <= 1'b0;
			wait_reg <= 4'h0;
			o_vec_seen <= 16'h0000;
			o_n_taken <= 8'h00;
		end else begin
			o_core_ack <= 1'b0;
			if (i_core_irq && !o_core_ack) begin
				if (wait_reg == i_delay) begin
					o_core_ack <= 1'b1;
					o_vec_seen <= i_core_vector;
					o_n_taken <= o_n_taken + 8'h01;
					wait_reg <= 4'h0;
				end else begin
					wait_reg <= wait_reg + 4'h1;
				end
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_return <= 1'b0;
		end else begin
			o_return <= i_ret_cmd;
		end
	end
endmodule
`default_nettype wire

// ===== two_level_interrupt_controller_test.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_test;
	import tlic_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ext0 = 1'b0;
	logic ret_cmd = 1'b0;
	logic [1:0] core_ev = 2'b00;
	logic [39:0] per_ev = 40'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] delay = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, core_irq, irq, ack, ret;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] core_vec, vec_seen;
	logic [7:0] n_taken;
	logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h30, 8'h50, 8'h70, 8'h74, 8'h7c};
	logic [31:0] rst [9] = '{32'h00, 32'hf5, 32'hc0, 32'h00, 32'h00, 32'hff, 32'h00, 32'h00, 32'h00};
	int n_errors = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	tlic_ctrl i_tlic_ctrl (.i_clk(clk), .i_resetn(rstn), .i_ext0_event(ext0),
		.i_core_event(core_ev), .i_periph_event(per_ev), .i_core_ack(ack),
		.i_return_from_irq(ret), .o_core_irq(core_irq), .o_core_vector(core_vec),
		.o_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tlic_core_model i_tlic_core_model (.i_clk(clk), .i_resetn(rstn), .i_core_irq(core_irq),
		.i_core_vector(core_vec), .o_core_ack(ack), .o_return(ret), .i_delay(delay),
		.i_ret_cmd(ret_cmd), .o_vec_seen(vec_seen), .o_n_taken(n_taken));
	task automatic print_verdict;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw, ta, tw;
		logic [1:0] s;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = awready;
			tw = wready;
			@(posedge clk);
			pa = pa && !ta;
			pw = pw && !tw;
			awvalid <= pa;
			wvalid <= pw;
		end
		do begin
			@(negedge clk);
			ta = bvalid;
			s = bresp;
			@(posedge clk);
		end while (!ta);
		bready <= 1'b0;
		// let an edge pass before the next request raises bready again
		@(posedge clk);
		chk("bresp", {30'h0, er}, {30'h0, s});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
		input string nm);
		logic t;
		logic [31:0] v;
		logic [1:0] s;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
		end while (!t);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			t = rvalid;
			v = rdata;
			s = rresp;
			@(posedge clk);
		end while (!t);
		rready <= 1'b0;
		@(posedge clk);
		chk("rresp", {30'h0, er}, {30'h0, s});
		if (er == 2'b00) chk(nm, e, v);
	endtask
	task automatic ev(input logic e, input logic [1:0] c, input logic [39:0] p);
		ext0 <= e;
		core_ev <= c;
		per_ev <= p;
		@(posedge clk);
		ext0 <= 1'b0;
		core_ev <= 2'b00;
		per_ev <= 40'h0;
		@(posedge clk);
	endtask
	task automatic take(input logic [7:0] n, input logic [15:0] v);
		int k;
		k = 0;
		while (n_taken !== n && k < 30) begin
			@(posedge clk);
			k++;
		end
		chk("takes", {24'h0, n}, {24'h0, n_taken});
		chk("vector", {16'h0, v}, {16'h0, vec_seen});
	endtask
	task automatic retn;
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (ofs[i]) rd(ofs[i], rst[i], 2'b00, "reset value");
		rd(8'h24, 32'h0, 2'b10, "unmapped");
		wr(8'h24, 32'hff, 2'b10);
		// compatibility mode
		wr(8'h50, 32'h00, 2'b00);
		ev(1'b0, 2'b10, 40'h1);
		rd(8'h10, 32'h01, 2'b00, "periph flag");
		rd(8'h00, 32'h04, 2'b00, "timer flag");
		wr(8'h30, 32'h01, 2'b00);
		wr(8'h00, 32'h40, 2'b00);
		repeat (5) @(posedge clk);
		take(8'd0, 16'h0000);
		wr(8'h00, 32'h80, 2'b00);
		repeat (5) @(posedge clk);
		take(8'd0, 16'h0000);
		wr(8'h00, 32'hc0, 2'b00);
		take(8'd1, TLIC_VEC_HIGH);
		rd(8'h00, 32'h40, 2'b00, "global cleared");
		wr(8'h10, 32'h00, 2'b00);
		retn;
		rd(8'h00, 32'hc0, 2'b00, "global re-set");
		// priority mode with a slow core
		wr(8'h00, 32'h10, 2'b00);
		wr(8'h70, 32'h80, 2'b00);
		delay <= 4'h3;
		ev(1'b0, 2'b00, 40'h1);
		wr(8'h00, 32'h50, 2'b00);
		repeat (5) @(posedge clk);
		take(8'd1, TLIC_VEC_HIGH);
		wr(8'h00, 32'hd0, 2'b00);
		take(8'd2, TLIC_VEC_LOW);
		rd(8'h00, 32'h90, 2'b00, "low enable cleared");
		ev(1'b1, 2'b00, 40'h0);
		take(8'd3, TLIC_VEC_HIGH);
		rd(8'h7c, 32'h03, 2'b00, "service state");
		rd(8'h00, 32'h12, 2'b00, "high enable cleared");
		// interrupt output: masked, raised, cleared
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h78, 32'h01, 2'b00);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(8'h74, 32'h07, 2'b00);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// nested returns
		wr(8'h00, 32'h10, 2'b00);
		wr(8'h10, 32'h00, 2'b00);
		retn;
		rd(8'h00, 32'h90, 2'b00, "high re-set");
		rd(8'h7c, 32'h01, 2'b00, "low still served");
		retn;
		rd(8'h00, 32'hd0, 2'b00, "low re-set");
		take(8'd3, TLIC_VEC_HIGH);
		// high and low pending together: high first, low after return
		ev(1'b1, 2'b00, 40'h1);
		take(8'd4, TLIC_VEC_HIGH);
		rd(8'h7c, 32'h02, 2'b00, "high before low");
		wr(8'h00, 32'h50, 2'b00);
		retn;
		take(8'd5, TLIC_VEC_LOW);
		print_verdict;
	end
endmodule
bind tlic_ctrl tlic_monitor i_tlic_monitor (.i_clk, .i_resetn, .i_core_ack, .o_core_irq,
	.o_core_vector, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire
